// File: kick_deglitch.sv
// Kick input de-glitcher: decodes high-high-low-low sample pattern as one trigger
`timescale 1ns/1ns
`default_nettype none
module kick_deglitch
(
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic ce,
  input  wire logic run,
  input  wire logic kick_input,
  output logic      trigger
);

  wdog_pkg::deglitch_s q;
  wdog_pkg::deglitch_s next_q;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  always_comb
  begin
    next_q = q;
    if (!run)
    begin
      next_q = '0;
    end
    else
    begin
      next_q.shift = {q.shift[2:0], kick_input};
      next_q.trigger = (next_q.shift == wdog_pkg::KICK_PATTERN);
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      q <= '0;
    end
    else if (ce)
    begin
      q <= next_q;
    end
  end

  assign trigger = q.trigger;

endmodule
`default_nettype wire

// File: kick_host.sv
// Host model pulsing the kick input
`timescale 1ns/1ns
`default_nettype none
module kick_host
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       go,
  input  wire logic [2:0] hi_len,
  output logic            kick_input
);
  logic [2:0] left;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      left       <= 3'h0;
      kick_input <= 1'b0;
    end
    else if (go)
    begin
      left       <= hi_len - 3'h1;
      kick_input <= 1'b1;
    end
    else if (left != 3'h0)
      left <= left - 3'h1;
    else
      kick_input <= 1'b0;
  end
endmodule
`default_nettype wire

// File: wdog_pkg.sv
// Package for the windowed watchdog: states, timing constants and carrier structs
// What this block does
// - Watching the kick input starts only once the monitored regulator is enabled and its output is power-good.
// - Enabling the monitored regulator enters the reset state, held for the reset hold time with the reset output low.
// - When the reset hold time ends the machine enters the ignore phase and releases the reset output.
// - After the ignore time the machine enters the initial accept phase with the reset output still released.
// - In initial accept a trigger moves at once to the closed window, and no trigger within the initial accept time returns to reset.
// - In the closed window a trigger sends the machine at once to reset, and an untriggered closed time leads to repeat accept.
// - In repeat accept a trigger returns at once to the closed window, and an untriggered accept time leads to reset.
// - A trigger is two high samples of the kick input followed by two low samples, so the host holds each level long enough.
// - A monitored regulator power failure forces the off state from any state and holds the reset output low until it is good.
// - An internal supply out of range halts the watchdog, which resumes when the supply is back in range.
// - On regulator dropout the reset output goes low only after the regulator has been out of range for the reset assert delay, shorter excursions ignored.
// - Supply lockout stops the watchdog, which recovers by itself when the lockout clears.
package wdog_pkg;

  // ----------------------------------------------------------------
  // Timing (one sample tick per clk cycle at 10 MHz)
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS       = 100;
  localparam int unsigned CNT_W               = 16;
  localparam int unsigned RESET_HOLD_NS       = 100000;
  localparam int unsigned IGNORE_NS           = 200000;
  localparam int unsigned INITIAL_ACCEPT_NS   = 400000;
  localparam int unsigned CLOSED_NS           = 100000;
  localparam int unsigned ACCEPT_NS           = 100000;
  localparam int unsigned ASSERT_DELAY_NS     = 2000;
  localparam logic [CNT_W-1:0] RESET_HOLD_CYC     = CNT_W'(RESET_HOLD_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] IGNORE_CYC         = CNT_W'(IGNORE_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] INITIAL_ACCEPT_CYC = CNT_W'(INITIAL_ACCEPT_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CLOSED_CYC         = CNT_W'(CLOSED_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] ACCEPT_CYC         = CNT_W'(ACCEPT_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] ASSERT_DELAY_CYC   = CNT_W'(ASSERT_DELAY_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CNT_ONE            = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_ZERO           = CNT_W'(0);
  // Oldest two samples high, newest two low
  localparam logic [3:0]       KICK_PATTERN       = 4'hC;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OFF,
    ST_RESET,
    ST_IGNORE,
    ST_INIT_ACCEPT,
    ST_CLOSED,
    ST_REPEAT_ACCEPT
  } wd_state_e;

  typedef struct packed {
    logic regulator_enable;
    logic regulator_good;
    logic internal_supply_ok;
    logic supply_lockout;
  } supply_s;

  typedef struct packed {
    logic [3:0] shift;
    logic       trigger;
  } deglitch_s;

  typedef struct packed {
    wd_state_e        state;
    logic [CNT_W-1:0] timer;
    logic [CNT_W-1:0] fail_cnt;
    logic             reg_failed;
    logic             rst_low;
    logic             state_pulse;
  } wd_s;

endpackage

// File: wdog_properties.sv
// Port checker for the windowed watchdog state machine
`timescale 1ns/1ns
`default_nettype none
module wdog_properties
(
  input wire logic                clk,
  input wire logic                rstn,
  input wire logic                ce,
  input wire wdog_pkg::supply_s   supply,
  input wire logic                kick_input,
  input wire logic                reset_out_o,
  input wire logic                reset_out_oe,
  input wire wdog_pkg::wd_state_e wd_state,
  input wire logic                state_change
);
  wire logic run = ce && supply.internal_supply_ok && !supply.supply_lockout;
  wire logic ok = run && supply.regulator_enable && supply.regulator_good;
  wire logic s_off = wd_state == wdog_pkg::ST_OFF;
  wire logic s_rst = wd_state == wdog_pkg::ST_RESET;
  wire logic s_ign = wd_state == wdog_pkg::ST_IGNORE;
  wire logic cl = ok && wd_state == wdog_pkg::ST_CLOSED;
  wire logic ra = ok && wd_state == wdog_pkg::ST_REPEAT_ACCEPT;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_pin; !reset_out_o && reset_out_oe == (s_off || s_rst); endproperty
  a_pin: assert property (p_pin)
    else $error("reset pin wrong for state");
  property p_start; s_off && ok |=> s_rst; endproperty
  a_start: assert property (p_start)
    else $error("no start after power good");
  property p_off; run && !supply.regulator_enable |=> s_off; endproperty
  a_off: assert property (p_off)
    else $error("no off after disable");
  property p_halt; !run |=> $stable(wd_state) && $stable(reset_out_oe); endproperty
  a_halt: assert property (p_halt)
    else $error("state moved while halted");
  property p_ign; s_ign && ok |=> s_ign || wd_state == wdog_pkg::ST_INIT_ACCEPT; endproperty
  a_ign: assert property (p_ign)
    else $error("ignore phase left wrongly");
  property p_cls; (cl && kick_input)[*2] ##1 (cl && !kick_input)[*2] |-> ##2 s_rst; endproperty
  a_cls: assert property (p_cls)
    else $error("kick in closed window missed");
  property p_rep; (ra && kick_input)[*2] ##1 (ra && !kick_input)[*2] |-> ##2 !s_rst && !s_off && !ra; endproperty
  a_rep: assert property (p_rep)
    else $error("kick in accept phase missed");
  property p_dip; $fell(supply.regulator_good) && supply.regulator_enable && run && !s_off |=> (!s_off)[*8]; endproperty
  a_dip: assert property (p_dip)
    else $error("off too soon after dip");
endmodule
bind windowed_watchdog_fsm wdog_properties u_props (.clk(clk), .rstn(rstn), .ce(ce), .supply(supply),
  .kick_input(kick_input), .reset_out_o(reset_out_o), .reset_out_oe(reset_out_oe), .wd_state(wd_state),
  .state_change(state_change));
`default_nettype wire

// File: windowed_watchdog_fsm.sv
// Windowed watchdog state machine with supervisor reset output
`timescale 1ns/1ns
`default_nettype none
module windowed_watchdog_fsm
(
  input  wire logic            clk,
  input  wire logic            rstn,
  input  wire logic            ce,
  input  wire wdog_pkg::supply_s supply,
  input  wire logic            kick_input,
  output logic                 reset_out_o,
  output logic                 reset_out_oe,
  output wdog_pkg::wd_state_e  wd_state,
  output logic                 state_change
);

  wdog_pkg::wd_s q;
  wdog_pkg::wd_s next_q;
  logic          trigger;
  logic          halted;
  logic          run;

  // ----------------------------------------------------------------
  // Halt conditions
  // ----------------------------------------------------------------
  // internal supply out of range halts
  assign halted = !supply.internal_supply_ok || supply.supply_lockout;
  // only watch outside the off and reset states
  assign run = !halted && (q.state != wdog_pkg::ST_OFF) && (q.state != wdog_pkg::ST_RESET);

  kick_deglitch u_deglitch
  (
    .clk        (clk),
    .rstn       (rstn),
    .ce         (ce && !halted),
    .run        (run),
    .kick_input (kick_input),
    .trigger    (trigger)
  );

  function automatic logic expired(input logic [wdog_pkg::CNT_W-1:0] t, input logic [wdog_pkg::CNT_W-1:0] lim);
    expired = (t >= lim - wdog_pkg::CNT_ONE);
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_q             = q;
    next_q.state_pulse = 1'b0;
    next_q.timer       = q.timer + wdog_pkg::CNT_ONE;

    // filter regulator dropouts shorter than the assert delay
    if (supply.regulator_good || !supply.regulator_enable)
    begin
      next_q.fail_cnt   = wdog_pkg::CNT_ZERO;
      next_q.reg_failed = !supply.regulator_enable;
    end
    else if (!q.reg_failed)
    begin
      next_q.fail_cnt = q.fail_cnt + wdog_pkg::CNT_ONE;
      if (expired(q.fail_cnt, wdog_pkg::ASSERT_DELAY_CYC))
      begin
        next_q.reg_failed = 1'b1;
      end
    end

    unique case (q.state)
      wdog_pkg::ST_OFF:
      begin
        // enabling and good regulator enters reset
        if (supply.regulator_enable && supply.regulator_good)
        begin
          next_q.state = wdog_pkg::ST_RESET;
          next_q.timer = wdog_pkg::CNT_ZERO;
        end
      end
      wdog_pkg::ST_RESET:
      begin
        // hold time over, go to ignore
        if (expired(q.timer, wdog_pkg::RESET_HOLD_CYC))
        begin
          next_q.state = wdog_pkg::ST_IGNORE;
          next_q.timer = wdog_pkg::CNT_ZERO;
        end
      end
      wdog_pkg::ST_IGNORE:
      begin
        if (expired(q.timer, wdog_pkg::IGNORE_CYC))
        begin
          next_q.state = wdog_pkg::ST_INIT_ACCEPT;
          next_q.timer = wdog_pkg::CNT_ZERO;
        end
      end
      wdog_pkg::ST_INIT_ACCEPT:
      begin
        if (trigger)
        begin
          next_q.state = wdog_pkg::ST_CLOSED;
          next_q.timer = wdog_pkg::CNT_ZERO;
        end
        else if (expired(q.timer, wdog_pkg::INITIAL_ACCEPT_CYC))
        begin
          next_q.state = wdog_pkg::ST_RESET;
          next_q.timer = wdog_pkg::CNT_ZERO;
        end
      end
      wdog_pkg::ST_CLOSED:
      begin
        if (trigger)
        begin
          next_q.state = wdog_pkg::ST_RESET;
          next_q.timer = wdog_pkg::CNT_ZERO;
        end
        else if (expired(q.timer, wdog_pkg::CLOSED_CYC))
        begin
          next_q.state = wdog_pkg::ST_REPEAT_ACCEPT;
          next_q.timer = wdog_pkg::CNT_ZERO;
        end
      end
      wdog_pkg::ST_REPEAT_ACCEPT:
      begin
        if (trigger)
        begin
          next_q.state = wdog_pkg::ST_CLOSED;
          next_q.timer = wdog_pkg::CNT_ZERO;
        end
        else if (expired(q.timer, wdog_pkg::ACCEPT_CYC))
        begin
          next_q.state = wdog_pkg::ST_RESET;
          next_q.timer = wdog_pkg::CNT_ZERO;
        end
      end
      default:
      begin
        next_q.state = wdog_pkg::ST_OFF;
        next_q.timer = wdog_pkg::CNT_ZERO;
      end
    endcase

    // regulator failure forces off from any state
    if (next_q.reg_failed)
    begin
      next_q.state = wdog_pkg::ST_OFF;
      next_q.timer = wdog_pkg::CNT_ZERO;
    end

    // output low in off and reset
    next_q.rst_low     = (next_q.state == wdog_pkg::ST_OFF) || (next_q.state == wdog_pkg::ST_RESET);
    next_q.state_pulse = (next_q.state != q.state);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Halt freezes everything, so the machine resumes where it stopped
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      q         <= '0;
      q.state   <= wdog_pkg::ST_OFF;
      q.rst_low <= 1'b1;
      q.reg_failed <= 1'b1;
    end
    else if (ce && !halted)
    begin
      q <= next_q;
    end
  end

  // Open drain: drive low only
  assign reset_out_o  = 1'b0;
  assign reset_out_oe = q.rst_low;
  assign wd_state     = q.state;
  assign state_change = q.state_pulse;

endmodule
`default_nettype wire

// File: windowed_watchdog_fsm_bench.sv
// Self-checking bench for the windowed watchdog
`timescale 1ns/1ns
`default_nettype none
module windowed_watchdog_fsm_bench;
  logic                clk;
  logic                rstn = 1'b0;
  logic                ce = 1'b1;
  wdog_pkg::supply_s   supply = 4'h2;
  logic                go = 1'b0;
  logic [2:0]          hi_len = 3'h2;
  logic                kick_input;
  logic                reset_out_o;
  logic                reset_out_oe;
  wdog_pkg::wd_state_e wd_state;
  logic                state_change;
  int                  fails = 0;
  int                  n_compared = 0;
  int                  cyc = 0;
  int                  last = 0;
  int                  qs[$];
  int                  qd[$];
  logic [31:0]         seed = 32'h9244;
  wdog_pkg::wd_state_e prev_st = wdog_pkg::ST_OFF;

  windowed_watchdog_fsm dut (.clk(clk), .rstn(rstn), .ce(ce), .supply(supply), .kick_input(kick_input),
    .reset_out_o(reset_out_o), .reset_out_oe(reset_out_oe), .wd_state(wd_state), .state_change(state_change));
  kick_host host (.clk(clk), .rstn(rstn), .go(go), .hi_len(hi_len), .kick_input(kick_input));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %0d seen %0d", what, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cy(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask

  task automatic ex(input int s, input int d);
    qs.push_back(s);
    qd.push_back(d);
  endtask

  task automatic kick(input int h);
    hi_len = 3'(h);
    go = 1'b1;
    cy(1);
    go = 1'b0;
  endtask

  task automatic wait_st(input wdog_pkg::wd_state_e s);
    int i;
    for (i = 0; i < 5000 && wd_state !== s; i++)
      cy(1);
    chk("state reached", wd_state, s);
  endtask

  // Model: each change pops the expected state and time spent in the previous one
  always @(negedge clk)
  begin
    cyc++;
    if (cyc > 40000)
    begin
      fails++;
      summarize();
    end
    else
    begin
      chk("change pulse", state_change, wd_state !== prev_st);
      if (wd_state !== prev_st)
      begin
        chk("state", wd_state, qs.size() ? qs[0] : 7);
        if (qs.size() && qd[0] >= 0)
          chk("time in state", cyc - last, qd[0]);
        chk("reset pin", reset_out_oe, qs.size() && qs[0] <= 1);
        chk("reset data", reset_out_o, 0);
        if (qs.size())
        begin
          void'(qs.pop_front());
          void'(qd.pop_front());
        end
        last = cyc;
      end
      prev_st = wd_state;
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    cy(5);
    rstn = 1'b1;
    cy(3);
    // power-up, kick during ignore is dropped
    ex(wdog_pkg::ST_RESET, -1);
    ex(wdog_pkg::ST_IGNORE, 1000);
    ex(wdog_pkg::ST_INIT_ACCEPT, 2000);
    supply.regulator_enable = 1'b1;
    supply.regulator_good = 1'b1;
    wait_st(wdog_pkg::ST_IGNORE);
    kick(2);
    // one kick per accept window at a random offset
    for (int i = 0; i < 5; i++)
    begin
      ex(wdog_pkg::ST_CLOSED, -1);
      ex(wdog_pkg::ST_REPEAT_ACCEPT, i == 4 ? 1120 : 1000);
      wait_st(i == 0 ? wdog_pkg::ST_INIT_ACCEPT : wdog_pkg::ST_REPEAT_ACCEPT);
      seed = lfsr(seed);
      cy(seed[7:0]);
      // Random high length: only the last two highs and two lows decode
      kick(2 + int'(seed[9:8]));
      wait_st(wdog_pkg::ST_CLOSED);
    end
    // one-sample glitch ignored, three halts stretch the window
    kick(1);
    cy(10);
    ce = 1'b0;
    cy(40);
    ce = 1'b1;
    supply.internal_supply_ok = 1'b0;
    cy(40);
    supply.internal_supply_ok = 1'b1;
    supply.supply_lockout = 1'b1;
    cy(40);
    supply.supply_lockout = 1'b0;
    // missed kicks and an early kick end in reset
    ex(wdog_pkg::ST_RESET, 1000);
    ex(wdog_pkg::ST_IGNORE, 1000);
    ex(wdog_pkg::ST_INIT_ACCEPT, 2000);
    ex(wdog_pkg::ST_RESET, 4000);
    ex(wdog_pkg::ST_IGNORE, 1000);
    ex(wdog_pkg::ST_INIT_ACCEPT, 2000);
    ex(wdog_pkg::ST_CLOSED, -1);
    ex(wdog_pkg::ST_RESET, -1);
    ex(wdog_pkg::ST_IGNORE, 1000);
    ex(wdog_pkg::ST_OFF, -1);
    ex(wdog_pkg::ST_RESET, -1);
    ex(wdog_pkg::ST_OFF, -1);
    wait_st(wdog_pkg::ST_INIT_ACCEPT);
    wait_st(wdog_pkg::ST_RESET);
    wait_st(wdog_pkg::ST_INIT_ACCEPT);
    kick(2);
    wait_st(wdog_pkg::ST_CLOSED);
    cy(20);
    kick(2);
    wait_st(wdog_pkg::ST_IGNORE);
    // short dip ignored, long dip and disable force off
    supply.regulator_good = 1'b0;
    cy(5);
    supply.regulator_good = 1'b1;
    cy(5);
    supply.regulator_good = 1'b0;
    wait_st(wdog_pkg::ST_OFF);
    supply.regulator_good = 1'b1;
    wait_st(wdog_pkg::ST_RESET);
    supply.regulator_enable = 1'b0;
    wait_st(wdog_pkg::ST_OFF);
    cy(5);
    chk("pending", qs.size(), 0);
    summarize();
  end
endmodule
`default_nettype wire
